// [hdl/svc_pkg.sv]
`default_nettype none
package svc_pkg;
  localparam int SVC_LEVEL_W = 8;
  localparam int SVC_STEP_W = 5;
  localparam logic [4:0] SVC_STEP_MAX = 5'h1f;
  localparam logic [4:0] SVC_STEP_RESET = 5'h00;
  // thresholds: boundary of step s sits at base + s * 8, hysteresis +/- 2
  localparam int SVC_THR_SHIFT = 3;
  localparam logic [8:0] SVC_HYST = 9'h002;
  localparam logic [8:0] SVC_SPK_BASE = 9'h000;
  localparam logic [8:0] SVC_LINE_BASE = 9'h004;
  // timing
  localparam int SVC_CLK_HZ = 10_000_000;
  localparam int SVC_OSC_HZ = 30;
  localparam int SVC_TICK_CYCLES = SVC_CLK_HZ / SVC_OSC_HZ;
  localparam logic [1:0] SVC_TICKS_PER_MOVE = 2'h3;
  localparam int SVC_MOVE_MS = 133;

  typedef struct packed {
    logic [7:0] volume;
    logic [7:0] offset;
    logic [7:0] ceiling;
  } svc_levels_t;
endpackage
`default_nettype wire

// [hdl/svc_step_hyst.sv]
`default_nettype none
module svc_step_hyst
  import svc_pkg::*;
#(
  parameter logic [8:0] BASE = 9'h000
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] level,
  output logic [4:0] step
);
  logic [4:0] step_q;
  logic [4:0] step_d;
  wire [8:0] level9 = {1'b0, level};
  wire [8:0] cur9 = {4'h0, step_q};
  wire [8:0] nxt9 = cur9 + 9'h001;
  // rising edge must clear a higher threshold than falling
  wire [8:0] up_thr = BASE + (nxt9 << SVC_THR_SHIFT) + SVC_HYST;
  wire [8:0] dn_thr = BASE + (cur9 << SVC_THR_SHIFT) - SVC_HYST;
  wire go_up = (step_q != SVC_STEP_MAX) && (level9 >= up_thr);
  wire go_dn = (step_q != 5'h00) && (level9 < dn_thr);

  always_comb
  begin
    step_d = step_q;
    if (go_up)
    begin
      step_d = step_q + 5'h01;
    end
    else if (go_dn)
    begin
      step_d = step_q - 5'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      step_q <= SVC_STEP_RESET;
    end
    else
    begin
      step_q <= step_d;
    end
  end

  assign step = step_q;
endmodule
`default_nettype wire

// [hdl/svc_volume_ctrl.sv]
`default_nettype none
module svc_volume_ctrl
  import svc_pkg::*;
#(
  parameter int TICK_CYCLES = SVC_TICK_CYCLES
)(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire svc_levels_t CONTROL_LEVELS,
  output logic [4:0] SPEAKER_GAIN_STEP,
  output logic [4:0] LINE_OUTPUT_GAIN_STEP,
  output logic [4:0] SPEAKER_TARGET_STEP,
  output logic [4:0] LINE_TARGET_STEP,
  output logic GAIN_SETTLED
);
  // levels are ratiometric codes: full scale equals the reference input
  svc_levels_t sync1_q;
  svc_levels_t sync2_q;

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= CONTROL_LEVELS;
      sync2_q <= sync1_q;
    end
  end

  // a word caught mid-change by the synchroniser is only taken once it repeats
  svc_levels_t sync3_q;
  svc_levels_t lvl_q;
  svc_levels_t lvl_d;
  wire code_steady = (sync2_q == sync3_q);

  assign lvl_d = code_steady ? sync2_q : lvl_q;

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      sync3_q <= '0;
      lvl_q <= '0;
    end
    else
    begin
      sync3_q <= sync2_q;
      lvl_q <= lvl_d;
    end
  end

  // line level, clamped at zero on underflow
  wire [8:0] diff9 = {1'b0, lvl_q.volume} - {1'b0, lvl_q.offset};
  wire [7:0] line_volume_level = diff9[8] ? 8'h00 : diff9[7:0];

  logic [4:0] spk_tgt;
  logic [4:0] line_raw;
  logic [4:0] ceil_step;

  svc_step_hyst #(.BASE(SVC_SPK_BASE)) u_spk_tbl (
    .clk(CLK),
    .rst_n(RESET_N),
    .level(lvl_q.volume),
    .step(spk_tgt)
  );

  // separate table; same index is 16 dB lower on the line stage
  svc_step_hyst #(.BASE(SVC_LINE_BASE)) u_line_tbl (
    .clk(CLK),
    .rst_n(RESET_N),
    .level(line_volume_level),
    .step(line_raw)
  );

  svc_step_hyst #(.BASE(SVC_LINE_BASE)) u_ceil_tbl (
    .clk(CLK),
    .rst_n(RESET_N),
    .level(lvl_q.ceiling),
    .step(ceil_step)
  );

  // target held in an extra register that the speaker path lacks, so the line target lags by one cycle
  wire line_capped = (ceil_step < line_raw);
  wire [4:0] line_tgt = line_capped ? ceil_step : line_raw;
  logic [4:0] line_tgt_q;

  // internal 30 Hz tick
  logic [31:0] div_q;
  logic [31:0] div_d;
  logic [1:0] tick_cnt_q;
  logic [1:0] tick_cnt_d;
  wire tick = (div_q == 32'(TICK_CYCLES - 1));
  wire move = tick && (tick_cnt_q == SVC_TICKS_PER_MOVE);

  assign div_d = tick ? 32'h0000_0000 : div_q + 32'h0000_0001;
  assign tick_cnt_d = tick ? tick_cnt_q + 2'h1 : tick_cnt_q;

  logic [4:0] spk_q;
  logic [4:0] spk_d;
  logic [4:0] line_q;
  logic [4:0] line_d;

  // each path steps once per move, toward its own target
  wire spk_up = move && (spk_q < spk_tgt);
  wire spk_dn = move && (spk_q > spk_tgt);
  wire line_up = move && (line_q < line_tgt_q);
  wire line_dn = move && (line_q > line_tgt_q);

  always_comb
  begin
    spk_d = spk_q;
    if (spk_up)
    begin
      spk_d = spk_q + 5'h01;
    end
    else if (spk_dn)
    begin
      spk_d = spk_q - 5'h01;
    end
  end

  always_comb
  begin
    line_d = line_q;
    if (line_up)
    begin
      line_d = line_q + 5'h01;
    end
    else if (line_dn)
    begin
      line_d = line_q - 5'h01;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      div_q <= 32'h0000_0000;
    end
    else
    begin
      div_q <= div_d;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      tick_cnt_q <= 2'h0;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_d;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      line_tgt_q <= SVC_STEP_RESET;
    end
    else
    begin
      line_tgt_q <= line_tgt;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      spk_q <= SVC_STEP_RESET;
    end
    else
    begin
      spk_q <= spk_d;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      line_q <= SVC_STEP_RESET;
    end
    else
    begin
      line_q <= line_d;
    end
  end

  wire spk_at_tgt = (spk_q == spk_tgt);
  wire line_at_tgt = (line_q == line_tgt_q);

  assign SPEAKER_GAIN_STEP = spk_q;
  assign LINE_OUTPUT_GAIN_STEP = line_q;
  assign SPEAKER_TARGET_STEP = spk_tgt;
  assign LINE_TARGET_STEP = line_tgt_q;
  assign GAIN_SETTLED = spk_at_tgt && line_at_tgt;
endmodule
`default_nettype wire

// [sim/svc_volume_monitor.sv]
`default_nettype none
module svc_volume_monitor
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [4:0] SPEAKER_GAIN_STEP,
  input wire logic [4:0] LINE_OUTPUT_GAIN_STEP,
  input wire logic [4:0] SPEAKER_TARGET_STEP,
  input wire logic [4:0] LINE_TARGET_STEP,
  input wire logic GAIN_SETTLED
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic [4:0] s = SPEAKER_GAIN_STEP;
  wire logic [4:0] l = LINE_OUTPUT_GAIN_STEP;
  wire logic [4:0] t = SPEAKER_TARGET_STEP;
  wire logic [4:0] u = LINE_TARGET_STEP;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  a_spk_step: assert property ($changed(s) |-> s - $past(s) inside {5'h01, 5'h1f})
    else $error("spk jump");
  a_line_step: assert property ($changed(l) |-> l - $past(l) inside {5'h01, 5'h1f})
    else $error("line jump");
  a_spk_dir: assert property ($changed(s) |-> s > $past(s) == $past(t) > $past(s))
    else $error("spk way");
  a_line_dir: assert property ($changed(l) |-> l > $past(l) == $past(u) > $past(l))
    else $error("line way");
  a_tgt_step: assert property ($changed(u) |-> u - $past(u) inside {5'h01, 5'h1f})
    else $error("target jump");
  a_move_gap: assert property ($changed(s) |=> $stable(s) [*7])
    else $error("gap");
  a_settle_flag: assert property (GAIN_SETTLED |=> $stable(s) && $stable(l))
    else $error("settled");
  a_reset_zero: assert property ($rose(RESET_N) |-> (s | l) == 5'h00)
    else $error("reset");
endmodule
bind svc_volume_ctrl svc_volume_monitor u_mon (.*);
`default_nettype wire

// [sim/svc_dac_model.sv]
`default_nettype none
module svc_dac_model
  import svc_pkg::*;
(
  input wire logic clk,
  input wire svc_levels_t code,
  output var svc_levels_t levels
);
  timeunit 1ns;
  timeprecision 1ns;
  // 8-bit codes never exceed reference
  always @(posedge clk) levels <= code;
endmodule
`default_nettype wire

// [sim/tb_top.sv]
`default_nettype none
module tb_top
  import svc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  int n, errors = 0, samples_checked = 0;
  svc_levels_t code = '0;
  svc_levels_t lv;
  logic [4:0] sg, lg, lt, st;
  logic gs;
  always #50 clk = ~clk;
  svc_dac_model dac (.clk(clk), .code(code), .levels(lv));
  svc_volume_ctrl #(.TICK_CYCLES(4)) uut (.CLK(clk), .RESET_N(rst_n), .CONTROL_LEVELS(lv),
    .SPEAKER_GAIN_STEP(sg), .LINE_OUTPUT_GAIN_STEP(lg), .SPEAKER_TARGET_STEP(st),
    .LINE_TARGET_STEP(lt), .GAIN_SETTLED(gs));
  task automatic check(input logic [4:0] seen, input logic [4:0] exp);
    samples_checked++;
    errors += int'(seen !== exp);
    if (seen !== exp) $display("BAD %0t %h %h", $time, seen, exp);
  endtask
  task automatic settle(input svc_levels_t c);
    @(posedge clk) code <= c;
    for (n = 0; (n < 40 || gs !== 1'b1) && n < 3000; n++) @(negedge clk);
    check(5'(gs), 5'h01);
  endtask
  task automatic t_full;
    settle('{8'hff, 8'h00, 8'h20});
    check(sg, 5'h1f);
    check(st, 5'h1f);
    check(lt, 5'h03);
    check(lg, 5'h03);
    check(5'(n >= 480), 5'h01);
    $display("t_full end");
  endtask
  task automatic t_off;
    settle('{8'h80, 8'h40, 8'hff});
    check(sg, 5'h10);
    check(lg, 5'h07);
    $display("t_off end");
  endtask
  task automatic t_hyst;
    settle('{8'h00, 8'h40, 8'hff});
    check(lt, 5'h00);
    settle('{8'h80, 8'h40, 8'hff});
    check(sg, 5'h0f);
    $display("t_hyst end");
  endtask
  task automatic tally_and_finish;
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_full();
    t_off();
    t_hyst();
    tally_and_finish();
  end
  initial
  begin
    #900000;
    errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
